// *** bench/irfc_top_assertions.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker
module irfc_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // read data
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  // flow control face
  input wire rate_fast_to_slow,
  input wire advanced_divisor_load,
  input wire advanced_mode_load,
  input wire flow_dma_rx,
  input wire flow_dma_tx,
  // handshake and receive path
  input wire [7:0] handshake_status_in,
  input wire [7:0] handshake_status_reg,
  input wire infrared_receive_pin,
  input wire primary_receive_pin,
  input wire receiver_data
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both pins equal and quiet
  sequence s_quiet;
    (infrared_receive_pin == primary_receive_pin && $stable(primary_receive_pin))[*6];
  endsequence
  // a load lasts one cycle
  sequence s_pulse;
    advanced_divisor_load ##1 !advanced_divisor_load;
  endsequence
  property p_load_cause;
    advanced_divisor_load |-> $past(rate_fast_to_slow) || $past(rate_fast_to_slow, 2);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("divisor load without rate switch");
  property p_mode_cause;
    advanced_mode_load |-> $past(rate_fast_to_slow) || $past(rate_fast_to_slow, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("mode load without rate switch");
  property p_pulse;
    advanced_divisor_load |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("divisor load longer than one cycle");
  property p_mode_with_div;
    advanced_divisor_load |-> advanced_mode_load;
  endproperty
  a_mode_with_div: assert property (p_mode_with_div)
    else $error("divisor load without mode load");
  property p_dma_excl;
    flow_dma_rx |-> !flow_dma_tx;
  endproperty
  a_dma_excl: assert property (p_dma_excl)
    else $error("both dma routes active");
  property p_hsk;
    handshake_status_reg != 8'h30 |-> handshake_status_reg == $past(handshake_status_in);
  endproperty
  a_hsk: assert property (p_hsk)
    else $error("handshake value neither fixed nor passed");
  property p_rx_route;
    s_quiet |-> receiver_data == primary_receive_pin;
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("receiver data differs from quiet pins");
  property p_rupper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rupper: assert property (p_rupper)
    else $error("upper read data not zero");
endmodule // irfc_chk

bind irfc_top irfc_chk u_chk (
  .aclk, .aresetn, .s_axi_rvalid, .s_axi_rdata, .rate_fast_to_slow,
  .advanced_divisor_load, .advanced_mode_load, .flow_dma_rx, .flow_dma_tx,
  .handshake_status_in, .handshake_status_reg, .infrared_receive_pin,
  .primary_receive_pin, .receiver_data
);

// *** bench/irfc_xcvr.sv ***
`timescale 1ns/1ps
// ==========================================
// infrared transceiver and frame end source
module irfc_xcvr (
  // clock
  input wire aclk,
  // receive pins, idle high
  output logic infrared_receive_pin,
  output logic primary_receive_pin,
  // frame end report
  output logic frame_end,
  output logic frame_lost,
  output logic [12:0] frame_byte_count,
  output logic max_length_exceeded,
  output logic physical_layer_error,
  output logic crc_error,
  output logic receive_fifo_overrun
);
  // idle levels at time zero
  initial
  begin
    {infrared_receive_pin, primary_receive_pin} = 2'b11;
    {frame_end, frame_lost} = 2'b00;
    frame_byte_count = 13'h0000;
    {max_length_exceeded, physical_layer_error, crc_error, receive_fifo_overrun} = 4'h0;
  end
  // one frame end or one lost frame, after a gap
  task automatic send(input logic [12:0] c, input logic [3:0] f, input logic lost, input int gap);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    frame_end <= !lost;
    frame_lost <= lost;
    frame_byte_count <= c;
    {max_length_exceeded, physical_layer_error, crc_error, receive_fifo_overrun} <= f;
    @(posedge aclk);
    {frame_end, frame_lost} <= 2'b00;
    frame_byte_count <= ~c; // stale fields no longer hold
    {max_length_exceeded, physical_layer_error, crc_error, receive_fifo_overrun} <= ~f;
  endtask
  // new levels on both receive pins
  task automatic pins(input logic a, input logic b);
    @(posedge aclk);
    infrared_receive_pin <= a;
    primary_receive_pin <= b;
  endtask
endmodule // irfc_xcvr

// *** bench/tb.sv ***
`timescale 1ns/1ps
// ==========================================
// self-checking bench
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, rate_fast_to_slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] handshake_status_in = 8'h5a, handshake_status_reg, bank_select;
  logic [15:0] advanced_baud_divisor;
  logic [2:0] advanced_handshake_mode;
  logic advanced_divisor_load, advanced_mode_load, flow_dma_rx, flow_dma_tx;
  logic auto_frame_split, full_duplex_select, status_fifo_interrupt, receiver_data;
  logic infrared_receive_pin, primary_receive_pin, frame_end, frame_lost;
  logic max_length_exceeded, physical_layer_error, crc_error, receive_fifo_overrun;
  logic [12:0] frame_byte_count;
  int errors = 0, compares = 0;
  logic [3:0] strb = 4'hf;
  always #2.5 aclk = ~aclk;
  irfc_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rate_fast_to_slow, .handshake_status_in, .advanced_baud_divisor,
    .advanced_divisor_load, .advanced_handshake_mode, .advanced_mode_load,
    .handshake_status_reg, .flow_dma_rx, .flow_dma_tx, .auto_frame_split,
    .full_duplex_select, .status_fifo_interrupt, .infrared_receive_pin,
    .primary_receive_pin, .receiver_data, .frame_end, .frame_lost, .frame_byte_count,
    .max_length_exceeded, .physical_layer_error, .crc_error, .receive_fifo_overrun,
    .bank_select
  );
  irfc_xcvr x (
    .aclk, .infrared_receive_pin, .primary_receive_pin, .frame_end, .frame_lost,
    .frame_byte_count, .max_length_exceeded, .physical_layer_error, .crc_error,
    .receive_fifo_overrun
  );
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a wait that ran out
  task automatic hang();
    errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    complete_run();
  endtask
  // one register write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= strb;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang();
    s_axi_bready <= 0;
    chk(s_axi_bresp, 2'b00);
    @(posedge aclk);
  endtask
  // one register read into rv and rr
  task automatic rd(input logic [5:0] a);
    int n;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang();
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  // read and compare
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, {24'h00_0000, e});
    chk(rr, 2'b00);
  endtask
  // rate switch pulse, watch for a load
  task automatic switch_rate(output logic seen);
    seen = 0;
    rate_fast_to_slow <= 1;
    @(posedge aclk);
    rate_fast_to_slow <= 0;
    repeat (8)
    begin
      @(posedge aclk);
      if (advanced_divisor_load) seen = 1;
    end
  endtask
  // reset values
  task automatic t_reset();
    rc(6'h08, 8'h00);
    rc(6'h10, 8'h00);
    rc(6'h0c, 8'hec);
    rc(6'h14, 8'h00);
    chk(bank_select, 8'hec);
  endtask
  // masks, set select, read-only and unmapped places
  task automatic t_regs();
    wr(6'h08, 8'hff);
    rc(6'h08, 8'hef);
    wr(6'h10, 8'hff);
    rc(6'h10, 8'h73);
    wr(6'h0c, 8'h05);
    chk(bank_select, 8'h05);
    rc(6'h0c, 8'hec);
    rd(6'h24);
    chk(rr, 2'b10);
    wr(6'h14, 8'hff);
    rc(6'h14, 8'h00);
    strb = 4'he;
    wr(6'h00, 8'h99);
    strb = 4'hf;
    rc(6'h00, 8'h00);
  endtask
  // divisor reload, mode copy, dma routing
  task automatic t_flow();
    logic s;
    wr(6'h00, 8'h34);
    wr(6'h04, 8'h12);
    wr(6'h08, 8'ha7);
    chk({flow_dma_tx, flow_dma_rx}, 2'b01);
    switch_rate(s);
    chk(s, 1'b1);
    chk(advanced_baud_divisor, 16'h1234);
    chk(advanced_handshake_mode, 3'b101);
    wr(6'h00, 8'h78);
    wr(6'h08, 8'ha5);
    switch_rate(s);
    chk(s, 1'b0);
    wr(6'h08, 8'h4e);
    chk({flow_dma_tx, flow_dma_rx}, 2'b00);
    switch_rate(s);
    chk(advanced_baud_divisor, 16'h1234);
    chk(advanced_handshake_mode, 3'b101);
    wr(6'h08, 8'h0d);
    chk({flow_dma_tx, flow_dma_rx}, 2'b10);
    wr(6'h08, 8'h0b);
    chk({flow_dma_tx, flow_dma_rx}, 2'b00);
  endtask
  // infrared config outputs and pin routing
  task automatic t_ircfg();
    wr(6'h10, 8'h33);
    chk({auto_frame_split, full_duplex_select}, 2'b11);
    chk(handshake_status_reg, 8'h30);
    x.pins(1'b0, 1'b1);
    repeat (6) @(posedge aclk);
    chk(receiver_data, 1'b0);
    wr(6'h10, 8'h00);
    repeat (6) @(posedge aclk);
    chk(handshake_status_reg, 8'h5a);
    chk({auto_frame_split, full_duplex_select}, 2'b00);
    chk(receiver_data, 1'b1);
  endtask
  // status entries, threshold, pops, overrun
  task automatic t_fifo();
    x.send(13'h1abc, 4'b1000, 0, 0);
    chk(status_fifo_interrupt, 1'b0);
    x.send(13'h0005, 4'b0110, 0, 3);
    x.send(13'h0007, 4'b0001, 0, 0);
    repeat (3) @(posedge aclk);
    chk(status_fifo_interrupt, 1'b1);
    rc(6'h14, 8'h90);
    rc(6'h18, 8'hbc);
    rc(6'h1c, 8'h1a);
    rc(6'h14, 8'h8c);
    rc(6'h1c, 8'h00);
    rc(6'h14, 8'h82);
    rc(6'h18, 8'h07);
    rc(6'h1c, 8'h00);
    rc(6'h14, 8'h00);
    wr(6'h10, 8'h40);
    for (int i = 0; i < 9; i++)
    begin
      x.send(13'(16 + i), 4'b0000, 0, 0);
      repeat (2) @(posedge aclk);
      if (i == 2) chk(status_fifo_interrupt, 1'b0);
      if (i == 3) chk(status_fifo_interrupt, 1'b1);
    end
    rc(6'h20, 8'h08);
    x.send(13'h0000, 4'b0000, 1, 0);
    rc(6'h14, 8'hc1);
    rc(6'h18, 8'h02);
    rc(6'h1c, 8'h00);
    rc(6'h14, 8'h80);
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_flow();
    t_ircfg();
    t_fifo();
    complete_run();
  end
endmodule // tb

// *** inc/irfc_defs.vh ***
`ifndef IRFC_DEFS_VH
`define IRFC_DEFS_VH
// ==========================================================
// register indices, byte address is index times four
`define IRFC_IDX_DIV_LO 3'h0
`define IRFC_IDX_DIV_HI 3'h1
`define IRFC_IDX_FLOW 3'h2
`define IRFC_IDX_BANK 3'h3
`define IRFC_IDX_IRCFG 3'h4
`define IRFC_IDX_FSTAT 3'h5
`define IRFC_IDX_LEN_LO 3'h6
`define IRFC_IDX_LEN_HI 3'h7
`define IRFC_IDX_STATUS 4'h8
// ==========================================================
// fixed read values and resets
`define IRFC_BANK_READ 8'hec
`define IRFC_BANK_RESET 8'hec
`define IRFC_HSK_DISABLED 8'h30
`define IRFC_ZERO8 8'h00
`define IRFC_FLOW_MASK 8'hef
`define IRFC_IRCFG_MASK 8'h73
// ==========================================================
// flow control setup fields
`define IRFC_FL_EN 0
`define IRFC_FL_RELOAD 1
`define IRFC_FL_DMA 2
`define IRFC_FL_SWAP 3
`define IRFC_FL_MODE_HI 7
`define IRFC_FL_MODE_LO 5
// ==========================================================
// infrared config fields
`define IRFC_FULL_DUPLEX_SELECT 0
`define IRFC_IR_HSKDIS 1
`define IRFC_IR_AUX 4
`define IRFC_IR_SPLIT 5
`define IRFC_IR_THR 6
// ==========================================================
// status entry fields
`define IRFC_ST_VALID 7
`define IRFC_ST_LOST 6
`define IRFC_ST_MAXLEN 4
`define IRFC_ST_PHY 3
`define IRFC_ST_CRC 2
`define IRFC_ST_RXOV 1
`define IRFC_ST_FOV 0
`define IRFC_THR_LOW 4'h2
`define IRFC_THR_HIGH 4'h4
`define IRFC_RESP_OKAY 2'b00
`define IRFC_RESP_SLVERR 2'b10
`endif

// *** logic/irfc_mem.v ***
`timescale 1ns/1ps
// ==========================================================
// small status memory, registered read
module irfc_mem #(
  parameter WIDTH = 17,
  parameter AW = 3
) (
  // clock
  input wire clk,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  // write and registered read
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    // write-through keeps a fresh bottom entry visible at once
    rd_data <= (wr_en && (wr_addr == rd_addr)) ? wr_data : mem[rd_addr];
  end
endmodule // irfc_mem

// *** logic/irfc_top.v ***
`timescale 1ns/1ps
`include "irfc_defs.vh"
// Summary of operation
// - bank select write stores, read returns ECH
// - reload divisor on fast-to-slow switch
// - flow bit 1 allows divisor reload
// - flow bits 7-5 copied to handshake mode
// - flow bit 3 picks rx or tx DMA
// - flow bit 2 enables DMA under flow
// - flow bit 0 gates bits 7-1; bit4 zero
// - config bit 6 threshold 2 or 4, interrupt
// - config bit 5 automatic frame splitting
// - config bit 4 routes auxiliary receive pin
// - config bit 1 forces handshake read 30H
// - config bit 0 selects full duplex
// - offset 5 shows oldest status entry
// - bit 7 marks valid bottom entry
// - bit 6 flags lost frames
// - bit 4 marks maximum length exceeded
// - bit 3 marks physical layer error
// - bit 2 marks CRC failure
// - bit 1 marks receive fifo overrun
// - bit 0 marks status fifo overrun
// - length high read pops the fifo
// - offset 6 shows lost count while lost
module irfc_top #(
  parameter DEPTH_LOG2 = 3
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // rate switch event and handshake register face
  input wire rate_fast_to_slow,
  input wire [7:0] handshake_status_in,
  output reg [15:0] advanced_baud_divisor,
  output reg advanced_divisor_load,
  output reg [2:0] advanced_handshake_mode,
  output reg advanced_mode_load,
  output reg [7:0] handshake_status_reg,
  // dma routing
  output reg flow_dma_rx,
  output reg flow_dma_tx,
  // infrared controls
  output reg auto_frame_split,
  output reg full_duplex_select,
  output reg status_fifo_interrupt,
  // receive pins
  input wire infrared_receive_pin,
  input wire primary_receive_pin,
  output reg receiver_data,
  // frame end events from receiver
  input wire frame_end,
  input wire frame_lost,
  input wire [12:0] frame_byte_count,
  input wire max_length_exceeded,
  input wire physical_layer_error,
  input wire crc_error,
  input wire receive_fifo_overrun,
  // bank visible to other register sets
  output reg [7:0] bank_select
);
  // ==========================================================
  // register state
  reg [7:0] flow_divisor_low;
  reg [7:0] flow_divisor_high;
  reg [7:0] flow_control_setup;
  reg [7:0] infrared_config_one;
  reg [7:0] lost_frame_count;
  reg frames_lost_flag;
  reg status_fifo_overrun;
  reg [DEPTH_LOG2-1:0] wr_ptr;
  reg [DEPTH_LOG2-1:0] rd_ptr;
  reg [DEPTH_LOG2:0] fill;
  reg [2:0] pin_sync_aux;
  reg [2:0] pin_sync_pri;
  reg aux_level;
  reg pri_level;
  reg wr_addr_held;
  reg wr_data_held;
  reg [5:0] wr_addr_q;
  reg [31:0] wr_data_q;
  reg [3:0] wr_strb_q;
  wire [16:0] bottom_entry;
  wire fifo_full;
  wire fifo_empty;
  wire push;
  wire pop;
  wire do_write;
  wire do_read;
  wire flow_on;
  wire [3:0] thr_level;
  wire [DEPTH_LOG2-1:0] next_rd_ptr;
  // ==========================================================
  // decode helpers
  function [3:0] reg_index;
    input [5:0] addr;
    begin
      reg_index = {addr[5], addr[4:2]};
    end
  endfunction
  function in_map;
    input [5:0] addr;
    begin
      in_map = (addr[1:0] == 2'b00) && (reg_index(addr) <= `IRFC_IDX_STATUS);
    end
  endfunction
  // ==========================================================
  // status fifo storage
  assign fifo_empty = (fill == {(DEPTH_LOG2+1){1'b0}});
  assign fifo_full = fill[DEPTH_LOG2];
  assign push = frame_end && !fifo_full;
  assign pop = do_read && (reg_index(s_axi_araddr) == {1'b0, `IRFC_IDX_LEN_HI})
    && in_map(s_axi_araddr) && !fifo_empty;
  assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  irfc_mem #(
    .WIDTH(17),
    .AW(DEPTH_LOG2)
  ) u_mem (
    .clk(aclk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data({max_length_exceeded, physical_layer_error, crc_error,
      receive_fifo_overrun, frame_byte_count}),
    .rd_addr(next_rd_ptr),
    .rd_data(bottom_entry)
  );
  // fifo pointers, overrun and lost tracking
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= {DEPTH_LOG2{1'b0}};
      rd_ptr <= {DEPTH_LOG2{1'b0}};
      fill <= {(DEPTH_LOG2+1){1'b0}};
      status_fifo_overrun <= 1'b0;
      frames_lost_flag <= 1'b0;
      lost_frame_count <= `IRFC_ZERO8;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      fill <= fill + {{DEPTH_LOG2{1'b0}}, push} - {{DEPTH_LOG2{1'b0}}, pop};
      // set wins over clear by pop
      if (frame_end && fifo_full)
      begin
        status_fifo_overrun <= 1'b1;
      end
      else if (pop)
      begin
        status_fifo_overrun <= 1'b0;
      end
      if (frame_lost || (frame_end && fifo_full))
      begin
        frames_lost_flag <= 1'b1;
        if (lost_frame_count != 8'hff)
        begin
          lost_frame_count <= lost_frame_count + 8'h01;
        end
      end
      else if (pop)
      begin
        frames_lost_flag <= 1'b0;
        lost_frame_count <= `IRFC_ZERO8;
      end
    end
  end
  // ==========================================================
  // axi write channel capture
  assign do_write = wr_addr_held && wr_data_held && !s_axi_bvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_addr_held <= 1'b0;
      wr_data_held <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IRFC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !wr_addr_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wr_data_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        wr_addr_held <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wr_data_held <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        wr_addr_held <= 1'b0;
        wr_data_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= in_map(wr_addr_q) ? `IRFC_RESP_OKAY : `IRFC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // register writes, low byte lane only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flow_divisor_low <= `IRFC_ZERO8;
      flow_divisor_high <= `IRFC_ZERO8;
      flow_control_setup <= `IRFC_ZERO8;
      infrared_config_one <= `IRFC_ZERO8;
      bank_select <= `IRFC_BANK_RESET;
    end
    else if (do_write && wr_strb_q[0] && in_map(wr_addr_q))
    begin
      case (reg_index(wr_addr_q))
        {1'b0, `IRFC_IDX_DIV_LO}: flow_divisor_low <= wr_data_q[7:0];
        {1'b0, `IRFC_IDX_DIV_HI}: flow_divisor_high <= wr_data_q[7:0];
        {1'b0, `IRFC_IDX_FLOW}: flow_control_setup <= wr_data_q[7:0] & `IRFC_FLOW_MASK;
        {1'b0, `IRFC_IDX_BANK}: bank_select <= wr_data_q[7:0];
        {1'b0, `IRFC_IDX_IRCFG}: infrared_config_one <= wr_data_q[7:0] & `IRFC_IRCFG_MASK;
        default: bank_select <= bank_select;
      endcase
    end
  end
  // ==========================================================
  // axi read channel
  assign do_read = s_axi_arvalid && s_axi_arready;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IRFC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= in_map(s_axi_araddr) ? `IRFC_RESP_OKAY : `IRFC_RESP_SLVERR;
        s_axi_rdata <= 32'h0000_0000;
        case (reg_index(s_axi_araddr))
          {1'b0, `IRFC_IDX_DIV_LO}: s_axi_rdata[7:0] <= flow_divisor_low;
          {1'b0, `IRFC_IDX_DIV_HI}: s_axi_rdata[7:0] <= flow_divisor_high;
          {1'b0, `IRFC_IDX_FLOW}: s_axi_rdata[7:0] <= flow_control_setup;
          {1'b0, `IRFC_IDX_BANK}: s_axi_rdata[7:0] <= `IRFC_BANK_READ;
          {1'b0, `IRFC_IDX_IRCFG}: s_axi_rdata[7:0] <= infrared_config_one;
          {1'b0, `IRFC_IDX_FSTAT}: s_axi_rdata[7:0] <= {!fifo_empty, frames_lost_flag,
            1'b0, fifo_empty ? 4'h0 : bottom_entry[16:13], status_fifo_overrun};
          {1'b0, `IRFC_IDX_LEN_LO}: s_axi_rdata[7:0] <= frames_lost_flag
            ? lost_frame_count : bottom_entry[7:0];
          {1'b0, `IRFC_IDX_LEN_HI}: s_axi_rdata[4:0] <= bottom_entry[12:8];
          `IRFC_IDX_STATUS: s_axi_rdata[7:0] <= {4'h0, fill};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // flow control actions
  assign flow_on = flow_control_setup[`IRFC_FL_EN];
  assign thr_level = infrared_config_one[`IRFC_IR_THR] ? `IRFC_THR_HIGH : `IRFC_THR_LOW;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      advanced_baud_divisor <= 16'h0000;
      advanced_divisor_load <= 1'b0;
      advanced_handshake_mode <= 3'h0;
      advanced_mode_load <= 1'b0;
      flow_dma_rx <= 1'b0;
      flow_dma_tx <= 1'b0;
      auto_frame_split <= 1'b0;
      full_duplex_select <= 1'b0;
      status_fifo_interrupt <= 1'b0;
      handshake_status_reg <= `IRFC_HSK_DISABLED;
    end
    else
    begin
      advanced_divisor_load <= 1'b0;
      advanced_mode_load <= 1'b0;
      if (rate_fast_to_slow && flow_on && flow_control_setup[`IRFC_FL_RELOAD])
      begin
        advanced_baud_divisor <= {flow_divisor_high, flow_divisor_low};
        advanced_divisor_load <= 1'b1;
      end
      if (rate_fast_to_slow && flow_on)
      begin
        advanced_handshake_mode <=
          flow_control_setup[`IRFC_FL_MODE_HI:`IRFC_FL_MODE_LO];
        advanced_mode_load <= 1'b1;
      end
      flow_dma_rx <= flow_on && flow_control_setup[`IRFC_FL_DMA]
        && !flow_control_setup[`IRFC_FL_SWAP];
      flow_dma_tx <= flow_on && flow_control_setup[`IRFC_FL_DMA]
        && flow_control_setup[`IRFC_FL_SWAP];
      auto_frame_split <= infrared_config_one[`IRFC_IR_SPLIT];
      full_duplex_select <= infrared_config_one[`IRFC_FULL_DUPLEX_SELECT];
      status_fifo_interrupt <= (fill >= thr_level[DEPTH_LOG2:0]);
      handshake_status_reg <= infrared_config_one[`IRFC_IR_HSKDIS]
        ? `IRFC_HSK_DISABLED : handshake_status_in;
    end
  end
  // ==========================================================
  // receive pin synchronisers and routing
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_sync_aux <= 3'b111;
      pin_sync_pri <= 3'b111;
      aux_level <= 1'b1;
      pri_level <= 1'b1;
      receiver_data <= 1'b1;
    end
    else
    begin
      pin_sync_aux <= {pin_sync_aux[1:0], infrared_receive_pin};
      pin_sync_pri <= {pin_sync_pri[1:0], primary_receive_pin};
      if (pin_sync_aux[1] == pin_sync_aux[2])
      begin
        aux_level <= pin_sync_aux[2];
      end
      if (pin_sync_pri[1] == pin_sync_pri[2])
      begin
        pri_level <= pin_sync_pri[2];
      end
      receiver_data <= infrared_config_one[`IRFC_IR_AUX] ? aux_level : pri_level;
    end
  end
endmodule // irfc_top
